// [cse_core.v]
// decode and execution of the add, and, shift and branch subset
// Operation
// RQ1 - mode zero: add carry, memory into accumulator
// RQ2 - mode one: add into x-addressed memory byte
// RQ3 - add: literal two cycles, page zero three; mode one takes four and five here
// RQ4 - and into accumulator or x-addressed byte
// RQ5 - shift left: accumulator two cycles, memory five
// RQ6 - shift left moves old bit 7 to carry
// RQ7 - shift left fills bit 0 with zero
// RQ8 - bit clear branch: four or five cycles
// RQ9 - bit set branch: same encoding and timing
// RQ10 - carry clear branch taken only when carry zero
// RQ11 - carry set branch taken only when carry one
// RQ12 - zero set branch taken only when zero one
// RQ13 - target is next address plus signed offset
// RQ14 - update n, v, z, c in customary way
`timescale 1ns/100ps
`include "cse_map.vh"

module cse_core #(
  parameter [15:0] RESET_PC = `CSE_RST_PC  // first opcode address
) (
  // clock and reset
  input  wire        i_sys_clk,
  input  wire        i_nrst,
  // memory bus, asynchronous read
  output reg  [15:0] o_mem_addr,
  output reg         o_mem_rd,
  output reg         o_mem_wr,
  output reg  [7:0]  o_mem_wdata,
  input  wire [7:0]  i_mem_rdata,
  // outside core state
  input  wire        i_index_mode,
  input  wire [7:0]  i_x_reg,
  // visible core state
  output reg  [7:0]  o_acc,
  output reg  [15:0] o_pc,
  output reg         o_flag_n,
  output reg         o_flag_v,
  output reg         o_flag_z,
  output reg         o_flag_c,
  output reg         o_sync,
  output reg         o_bad_op
);

  ////////////////////////////////////////////////////////////////////////
  // one-hot states
  localparam [11:0] S_FETCH = 12'h001;  // opcode on the bus
  localparam [11:0] S_ZPA   = 12'h002;  // page-zero address byte
  localparam [11:0] S_OPND  = 12'h004;  // operand byte
  localparam [11:0] S_XRMW  = 12'h008;  // x-addressed byte read
  localparam [11:0] S_XWR   = 12'h010;  // x-addressed byte write
  localparam [11:0] S_ONE   = 12'h020;  // single byte instruction
  localparam [11:0] S_RMW   = 12'h040;  // shift operand read
  localparam [11:0] S_MOD   = 12'h080;  // shift internal cycle
  localparam [11:0] S_WR    = 12'h100;  // shift result write
  localparam [11:0] S_BZD   = 12'h200;  // bit test
  localparam [11:0] S_BIT   = 12'h400;  // bit branch spacer
  localparam [11:0] S_REL   = 12'h800;  // offset byte

  ////////////////////////////////////////////////////////////////////////
  // state registers and next values
  reg [11:0] state_q, state_d;
  reg [7:0]  ir_q,    ir_d;     // opcode being executed
  reg [15:0] pc_q,    pc_d;     // opcode address until the end
  reg [7:0]  acc_q,   acc_d;
  reg [7:0]  opb_q,   opb_d;    // latched operand or result
  reg [15:0] ea_q,    ea_d;     // effective address
  reg        cond_q,  cond_d;   // latched bit test outcome
  reg        mode_q,  mode_d;   // index-memory mode at fetch
  reg        n_q, n_d, v_q, v_d, z_q, z_d, c_q, c_d;
  reg [15:0] addr_d;
  reg        rd_d, wr_d, sync_d, bad_d, flag_we;
  reg [7:0]  wdata_d;
  reg [15:0] base;              // address after the branch
  reg        take;

  // alu hookup
  wire [1:0] alu_sel;
  wire [7:0] alu_a;
  wire [7:0] alu_b;
  wire [7:0] alu_res;
  wire       alu_n, alu_v, alu_z, alu_c;

  ////////////////////////////////////////////////////////////////////////
  // decode class of an opcode
  function [3:0] op_class;
    input [7:0] op;
    begin
      if (op == `CSE_OP_ADC_LIT || op == `CSE_OP_AND_LIT)
        op_class = `CSE_K_ALU_LIT;
      else if (op == `CSE_OP_ADC_PZ || op == `CSE_OP_AND_PZ)
        op_class = `CSE_K_ALU_PZ;
      else if (op == `CSE_OP_SHL_ACC)
        op_class = `CSE_K_SHL_ACC;
      else if (op == `CSE_OP_SHL_PZ)
        op_class = `CSE_K_SHL_PZ;
      else if (op[3:0] == `CSE_BB_ACC_NIB)
        op_class = `CSE_K_BB_ACC;
      else if (op[3:0] == `CSE_BB_PZ_NIB)
        op_class = `CSE_K_BB_PZ;
      else if (op == `CSE_OP_BR_CC || op == `CSE_OP_BR_CS || op == `CSE_OP_BR_ZS)
        op_class = `CSE_K_BR;
      else
        op_class = `CSE_K_BAD;
    end
  endfunction

  // alu operation of an opcode; shifts and the rest fall to shift
  function [1:0] op_alu;
    input [7:0] op;
    begin
      if (op == `CSE_OP_ADC_LIT || op == `CSE_OP_ADC_PZ)
        op_alu = `CSE_ALU_ADD;
      else if (op == `CSE_OP_AND_LIT || op == `CSE_OP_AND_PZ)
        op_alu = `CSE_ALU_AND;
      else
        op_alu = `CSE_ALU_SHL;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // operand routing: x-path and memory shift take memory as the a side
  assign alu_sel = op_alu(ir_q);
  assign alu_a   = (state_q == S_XRMW || state_q == S_RMW) ? i_mem_rdata : acc_q;
  assign alu_b   = (state_q == S_XRMW) ? opb_q : i_mem_rdata;

  cse_alu u_alu (
    .i_sel (alu_sel),
    .i_a   (alu_a),
    .i_b   (alu_b),
    .i_cin (c_q),
    .o_res (alu_res),
    .o_n   (alu_n),
    .o_v   (alu_v),
    .o_z   (alu_z),
    .o_c   (alu_c)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer: every bus request is prepared one cycle ahead
  always @* begin
    state_d = state_q;
    ir_d    = ir_q;
    pc_d    = pc_q;
    acc_d   = acc_q;
    opb_d   = opb_q;
    ea_d    = ea_q;
    cond_d  = cond_q;
    mode_d  = mode_q;
    addr_d  = o_mem_addr;
    wdata_d = o_mem_wdata;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    bad_d   = 1'b0;
    flag_we = 1'b0;
    base    = pc_q + ((op_class(ir_q) == `CSE_K_BB_PZ) ? 16'h0003 : 16'h0002);
    take    = cond_q;
    case (state_q)
      S_FETCH: begin
        ir_d   = i_mem_rdata;
        mode_d = i_index_mode;  // mode is fixed for the instruction
        addr_d = pc_q + 16'h0001;
        case (op_class(i_mem_rdata))
          `CSE_K_ALU_LIT: begin
            state_d = S_OPND;   // RQ3
            rd_d    = 1'b1;
          end
          `CSE_K_ALU_PZ, `CSE_K_SHL_PZ, `CSE_K_BB_PZ: begin
            state_d = S_ZPA;
            rd_d    = 1'b1;
          end
          `CSE_K_BR: begin
            state_d = S_REL;
            rd_d    = 1'b1;
          end
          `CSE_K_BB_ACC: begin
            state_d = S_BZD;    // RQ8
          end
          default: begin
            state_d = S_ONE;
          end
        endcase
      end
      S_ZPA: begin
        ea_d   = {`CSE_PZ_PAGE, i_mem_rdata};
        addr_d = {`CSE_PZ_PAGE, i_mem_rdata};
        rd_d   = 1'b1;
        if (op_class(ir_q) == `CSE_K_SHL_PZ)
          state_d = S_RMW;
        else if (op_class(ir_q) == `CSE_K_BB_PZ)
          state_d = S_BZD;
        else
          state_d = S_OPND;
      end
      S_OPND: begin
        if (mode_q) begin
          // x path: keep the operand, read the x-addressed byte
          opb_d   = i_mem_rdata;
          ea_d    = {`CSE_PZ_PAGE, i_x_reg};
          addr_d  = {`CSE_PZ_PAGE, i_x_reg};
          rd_d    = 1'b1;
          state_d = S_XRMW;
        end else begin
          acc_d   = alu_res;    // RQ1 RQ4
          flag_we = 1'b1;
          pc_d    = pc_q + 16'h0002;
          addr_d  = pc_q + 16'h0002;
          rd_d    = 1'b1;
          state_d = S_FETCH;
        end
      end
      S_XRMW: begin
        flag_we = 1'b1;         // RQ14
        wdata_d = alu_res;      // RQ2 RQ4
        addr_d  = ea_q;
        wr_d    = 1'b1;
        state_d = S_XWR;
      end
      S_XWR: begin
        pc_d    = pc_q + 16'h0002;
        addr_d  = pc_q + 16'h0002;
        rd_d    = 1'b1;
        state_d = S_FETCH;
      end
      S_ONE: begin
        if (op_class(ir_q) == `CSE_K_SHL_ACC) begin
          acc_d   = alu_res;    // RQ5
          flag_we = 1'b1;
        end else begin
          bad_d   = 1'b1;       // unknown opcode steps over one byte
        end
        pc_d    = pc_q + 16'h0001;
        addr_d  = pc_q + 16'h0001;
        rd_d    = 1'b1;
        state_d = S_FETCH;
      end
      S_RMW: begin
        opb_d   = alu_res;      // RQ5
        flag_we = 1'b1;
        state_d = S_MOD;
      end
      S_MOD: begin
        wdata_d = opb_q;
        addr_d  = ea_q;
        wr_d    = 1'b1;
        state_d = S_WR;
      end
      S_WR: begin
        pc_d    = pc_q + 16'h0002;
        addr_d  = pc_q + 16'h0002;
        rd_d    = 1'b1;
        state_d = S_FETCH;
      end
      S_BZD: begin
        // branch when the chosen bit differs from the sense bit
        if (op_class(ir_q) == `CSE_K_BB_PZ)
          cond_d = i_mem_rdata[ir_q[`CSE_BB_SEL_HI:`CSE_BB_SEL_LO]]
                   ^ ir_q[`CSE_BB_SENSE_BIT];  // RQ8 RQ9
        else
          cond_d = acc_q[ir_q[`CSE_BB_SEL_HI:`CSE_BB_SEL_LO]]
                   ^ ir_q[`CSE_BB_SENSE_BIT];  // RQ8 RQ9
        state_d = S_BIT;
      end
      S_BIT: begin
        addr_d  = base - 16'h0001;  // offset is the last byte
        rd_d    = 1'b1;
        state_d = S_REL;
      end
      S_REL: begin
        if (op_class(ir_q) == `CSE_K_BR) begin
          if (ir_q == `CSE_OP_BR_CC)
            take = ~c_q;        // RQ10
          else if (ir_q == `CSE_OP_BR_CS)
            take = c_q;         // RQ11
          else
            take = z_q;         // RQ12
        end
        if (take)
          pc_d = base + {{8{i_mem_rdata[7]}}, i_mem_rdata};  // RQ13
        else
          pc_d = base;
        addr_d  = pc_d;
        rd_d    = 1'b1;
        state_d = S_FETCH;
      end
      default: begin
        // lost state: restart fetch at the held address
        addr_d  = pc_q;
        rd_d    = 1'b1;
        state_d = S_FETCH;
      end
    endcase
    sync_d = (state_d == S_FETCH);
  end

  ////////////////////////////////////////////////////////////////////////
  // flag update by operation
  always @* begin
    n_d = n_q;
    v_d = v_q;
    z_d = z_q;
    c_d = c_q;
    if (flag_we) begin
      n_d = alu_n;              // RQ14
      z_d = alu_z;
      if (alu_sel == `CSE_ALU_ADD)
        v_d = alu_v;
      if (alu_sel != `CSE_ALU_AND)
        c_d = alu_c;            // RQ6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers, synchronous active-low reset
  always @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      state_q     <= S_FETCH;
      ir_q        <= 8'h00;
      pc_q        <= RESET_PC;
      acc_q       <= `CSE_RST_ACC;
      opb_q       <= 8'h00;
      ea_q        <= 16'h0000;
      cond_q      <= 1'b0;
      mode_q      <= 1'b0;
      n_q         <= 1'b0;
      v_q         <= 1'b0;
      z_q         <= 1'b0;
      c_q         <= 1'b0;
      o_mem_addr  <= RESET_PC;
      o_mem_rd    <= 1'b1;
      o_mem_wr    <= 1'b0;
      o_mem_wdata <= 8'h00;
      o_sync      <= 1'b1;
      o_bad_op    <= 1'b0;
      o_acc       <= `CSE_RST_ACC;
      o_pc        <= RESET_PC;
      o_flag_n    <= 1'b0;
      o_flag_v    <= 1'b0;
      o_flag_z    <= 1'b0;
      o_flag_c    <= 1'b0;
    end else begin
      state_q     <= state_d;
      ir_q        <= ir_d;
      pc_q        <= pc_d;
      acc_q       <= acc_d;
      opb_q       <= opb_d;
      ea_q        <= ea_d;
      cond_q      <= cond_d;
      mode_q      <= mode_d;
      n_q         <= n_d;
      v_q         <= v_d;
      z_q         <= z_d;
      c_q         <= c_d;
      o_mem_addr  <= addr_d;
      o_mem_rd    <= rd_d;
      o_mem_wr    <= wr_d;
      o_mem_wdata <= wdata_d;
      o_sync      <= sync_d;
      o_bad_op    <= bad_d;
      o_acc       <= acc_d;
      o_pc        <= pc_d;
      o_flag_n    <= n_d;
      o_flag_v    <= v_d;
      o_flag_z    <= z_d;
      o_flag_c    <= c_d;
    end
  end

endmodule

// [cse_map.vh]
// opcode encodings, decode classes, alu selects and reset values of the subset core
`ifndef CSE_MAP_VH
`define CSE_MAP_VH

// opcodes with a fixed encoding
`define CSE_OP_ADC_LIT      8'h69
`define CSE_OP_ADC_PZ       8'h65
`define CSE_OP_AND_LIT      8'h29
`define CSE_OP_AND_PZ       8'h25
`define CSE_OP_SHL_ACC      8'h0a
`define CSE_OP_SHL_PZ       8'h06
`define CSE_OP_BR_CC        8'h90
`define CSE_OP_BR_CS        8'hb0
`define CSE_OP_BR_ZS        8'hf0

// bit branches: low nibble picks the form, op[7:5] the bit, op[4] clear/set
`define CSE_BB_ACC_NIB      4'h3
`define CSE_BB_PZ_NIB       4'h7
`define CSE_BB_SENSE_BIT    4
`define CSE_BB_SEL_HI       7
`define CSE_BB_SEL_LO       5

// decode classes
`define CSE_K_ALU_LIT       4'h0
`define CSE_K_ALU_PZ        4'h1
`define CSE_K_SHL_ACC       4'h2
`define CSE_K_SHL_PZ        4'h3
`define CSE_K_BB_ACC        4'h4
`define CSE_K_BB_PZ         4'h5
`define CSE_K_BR            4'h6
`define CSE_K_BAD           4'h7

// alu selects
`define CSE_ALU_ADD         2'h0
`define CSE_ALU_AND         2'h1
`define CSE_ALU_SHL         2'h2

// reset values and the page-zero high byte
`define CSE_RST_PC          16'h0000
`define CSE_RST_ACC         8'h00
`define CSE_PZ_PAGE         8'h00

`endif

// [cse_alu.v]
// combinational add, and and shift unit with flag results
`timescale 1ns/100ps
`include "cse_map.vh"

module cse_alu (
  // operation select and operands
  input  wire [1:0] i_sel,
  input  wire [7:0] i_a,
  input  wire [7:0] i_b,
  input  wire       i_cin,
  // result and flags
  output reg  [7:0] o_res,
  output reg        o_n,
  output reg        o_v,
  output reg        o_z,
  output reg        o_c
);

  reg [8:0] sum;  // nine bits keep the carry out

  ////////////////////////////////////////////////////////////////////////
  // decimal mode is not modelled; the sum is always binary
  always @* begin
    sum   = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
    o_res = 8'h00;
    o_v   = 1'b0;
    o_c   = i_cin;
    case (i_sel)
      `CSE_ALU_ADD: begin
        o_res = sum[7:0];
        o_c   = sum[8];
        o_v   = (i_a[7] == i_b[7]) && (sum[7] != i_a[7]);
      end
      `CSE_ALU_AND: begin
        o_res = i_a & i_b;
      end
      `CSE_ALU_SHL: begin
        o_res = {i_a[6:0], 1'b0};  // RQ7
        o_c   = i_a[7];            // RQ6
      end
      default: begin
        o_res = 8'h00;
      end
    endcase
    o_n = o_res[7];
    o_z = (o_res == 8'h00);
  end

endmodule

// [cse_mem.sv]
// behavioural program and data memory answering the core in the same cycle
`timescale 1ns/100ps
module cse_mem (
  // clock
  input  wire logic        i_sys_clk,
  // bus from the core
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  // read data back to the core
  output logic      [7:0]  o_rdata
);
  logic [7:0] ram [0:1023];  // small store, address folded to ten bits
  logic [7:0] last_q;        // last value seen on the read lines
  //////////////////////////////////////////////////////////////////////////
  // idle lines show the inverse of the value on the read lines one cycle before
  always @* begin
    o_rdata = i_rd ? ram[i_addr[9:0]] : ~last_q;
  end
  // write commits at the edge that ends the write cycle
  always @(posedge i_sys_clk) begin
    last_q <= o_rdata;
    if (i_wr) begin
      ram[i_addr[9:0]] <= i_wdata;
    end
  end
endmodule

// [cse_core_checker.sv]
// assertions on the ports of the subset execution core
`timescale 1ns/100ps
module cse_core_checker (
  // clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  // memory bus
  input wire logic [15:0] o_mem_addr,
  input wire logic        o_mem_rd,
  input wire logic        o_mem_wr,
  input wire logic [7:0]  o_mem_wdata,
  input wire logic [7:0]  i_mem_rdata,
  // core state
  input wire logic        i_index_mode,
  input wire logic [7:0]  i_x_reg,
  input wire logic [7:0]  o_acc,
  input wire logic [15:0] o_pc,
  input wire logic        o_flag_n,
  input wire logic        o_flag_v,
  input wire logic        o_flag_z,
  input wire logic        o_flag_c,
  input wire logic        o_sync,
  input wire logic        o_bad_op
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  //////////////////////////////////////////////////////////////////////////
  logic [7:0]  acc_p_q;  // accumulator one cycle back
  logic [7:0]  op_q;     // opcode of the running instruction
  logic [15:0] tgt_q;    // target if the last byte read was an offset
  logic [15:0] nxt_q;    // fall-through address
  wire         take;     // branch condition of the running opcode
  assign take = (op_q == 8'h90 && !o_flag_c) || (op_q == 8'hb0 && o_flag_c) ||
                (op_q == 8'hf0 && o_flag_z);
  // history kept every cycle, the opcode on fetch cycles only, so the properties stay short
  always @(posedge i_sys_clk) begin
    acc_p_q <= o_acc;
    tgt_q   <= o_mem_addr + 16'h0001 + {{8{i_mem_rdata[7]}}, i_mem_rdata};
    nxt_q   <= o_mem_addr + 16'h0001;
    if (o_sync) begin
      op_q <= i_mem_rdata;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  property p_sync_pc;
    o_sync |-> o_mem_rd && !o_mem_wr && o_mem_addr == o_pc;
  endproperty
  a_sync_pc: assert property (p_sync_pc) else $error("fetch not at pc");
  property p_lit_add;
    o_sync && !i_index_mode && i_mem_rdata == 8'h69
      |=> o_mem_addr == $past(o_mem_addr) + 16'h0001 ##1 o_sync;
  endproperty
  a_lit_add: assert property (p_lit_add) else $error("literal add length");
  property p_pz_add;
    o_sync && !i_index_mode && i_mem_rdata == 8'h65 |=> !o_sync [*2] ##1 o_sync;
  endproperty
  a_pz_add: assert property (p_pz_add) else $error("page zero add length");
  property p_x_write;
    o_mem_wr && i_index_mode && op_q != 8'h06 |-> o_mem_addr == {8'h00, i_x_reg};
  endproperty
  a_x_write: assert property (p_x_write) else $error("write not at x");
  property p_acc_shift;
    o_sync && i_mem_rdata == 8'h0a |=> !o_mem_rd && !o_mem_wr
      ##1 o_sync && o_acc == {acc_p_q[6:0], 1'b0} && o_flag_c == acc_p_q[7];
  endproperty
  a_acc_shift: assert property (p_acc_shift) else $error("acc shift wrong");
  property p_pz_shift;
    o_sync && i_mem_rdata == 8'h06
      |=> !o_sync [*3] ##1 (o_mem_wr && !o_mem_wdata[0]) ##1 o_sync;
  endproperty
  a_pz_shift: assert property (p_pz_shift) else $error("page zero shift wrong");
  property p_bb_acc;
    o_sync && i_mem_rdata[3:0] == 4'h3 |=> !o_sync [*3] ##1 o_sync;
  endproperty
  a_bb_acc: assert property (p_bb_acc) else $error("acc bit branch length");
  property p_bb_pz;
    o_sync && i_mem_rdata[3:0] == 4'h7 |=> !o_sync [*4] ##1 o_sync;
  endproperty
  a_bb_pz: assert property (p_bb_pz) else $error("page zero bit branch length");
  property p_branch;
    o_sync && (i_mem_rdata == 8'h90 || i_mem_rdata == 8'hb0 || i_mem_rdata == 8'hf0)
      |=> ##1 o_sync && o_mem_addr == (take ? tgt_q : nxt_q);
  endproperty
  a_branch: assert property (p_branch) else $error("flag branch wrong");
  // main scenarios reached
  c_pz_shift: cover property (o_sync && i_mem_rdata == 8'h06);
  c_x_write: cover property (o_mem_wr && i_index_mode);
  c_bb_pz: cover property (o_sync && i_mem_rdata[3:0] == 4'h7);
endmodule

bind cse_core cse_core_checker u_chk (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
  .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
  .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .i_index_mode(i_index_mode),
  .i_x_reg(i_x_reg), .o_acc(o_acc), .o_pc(o_pc), .o_flag_n(o_flag_n),
  .o_flag_v(o_flag_v), .o_flag_z(o_flag_z), .o_flag_c(o_flag_c), .o_sync(o_sync),
  .o_bad_op(o_bad_op));

// [cse_core_bench.sv]
// self-checking bench for the subset execution core
`timescale 1ns/100ps
module cse_core_bench;
  logic        i_sys_clk;     // 50 MHz clock
  logic        i_nrst;        // sync reset, low active
  logic        i_index_mode;  // add and and results to the x-addressed byte
  logic [7:0]  i_x_reg;       // index register
  wire  [15:0] o_mem_addr;
  wire         o_mem_rd;
  wire         o_mem_wr;
  wire  [7:0]  o_mem_wdata;
  wire  [7:0]  i_mem_rdata;
  wire  [7:0]  o_acc;
  wire  [15:0] o_pc;
  wire         o_flag_n;
  wire         o_flag_v;
  wire         o_flag_z;
  wire         o_flag_c;
  wire         o_sync;
  wire         o_bad_op;         // skipped-opcode pulse
  integer      fail_count;       // mismatches seen
  integer      samples_checked;  // comparisons made
  //////////////////////////////////////////////////////////////////////////
  cse_core dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .o_mem_addr(o_mem_addr),
    .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata),
    .i_mem_rdata(i_mem_rdata), .i_index_mode(i_index_mode), .i_x_reg(i_x_reg),
    .o_acc(o_acc), .o_pc(o_pc), .o_flag_n(o_flag_n), .o_flag_v(o_flag_v),
    .o_flag_z(o_flag_z), .o_flag_c(o_flag_c), .o_sync(o_sync), .o_bad_op(o_bad_op));
  cse_mem mem (.i_sys_clk(i_sys_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd),
    .i_wr(o_mem_wr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  // free-running clock, 20 ns period
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  // compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // place n program bytes, first byte leftmost
  task ld(input logic [15:0] a, input logic [63:0] v, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        mem.ram[a + i] = v[8 * (n - 1 - i) +: 8];
      end
    end
  endtask
  // reset for two cycles, the next cycle fetches at zero
  task boot(input logic t);
    begin
      @(posedge i_sys_clk);
      i_nrst       <= 1'b0;
      i_index_mode <= t;
      repeat (2) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
    end
  endtask
  // run one instruction, check its cycle count and the next pc
  task step(input integer n, input logic [15:0] pc);
    integer k;
    begin
      k = 0;
      do begin
        @(posedge i_sys_clk);
        #1;
        k = k + 1;
      end while (o_sync !== 1'b1 && k < 20);
      chk(k[15:0], n[15:0]);
      chk(o_pc, pc);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // add with carry into the accumulator, both forms
  task t_add;
    begin
      ld(0, 48'h6905_6510_6900, 6);
      mem.ram[16'h10] = 8'hfc;
      boot(1'b0);
      step(2, 16'h0002);
      chk(o_acc, 16'h0005);
      step(3, 16'h0004);
      chk({o_acc, 7'h00, o_flag_c}, 16'h0101);
      step(2, 16'h0006);
      chk({o_acc, 7'h00, o_flag_c}, 16'h0200);
    end
  endtask
  // x-addressed results leave the accumulator alone
  task t_index;
    begin
      ld(0, 32'h6901_2530, 4);
      mem.ram[16'h20] = 8'h7f;
      mem.ram[16'h30] = 8'h0f;
      boot(1'b1);
      step(4, 16'h0002);
      chk({mem.ram[16'h20], o_acc}, 16'h8000);
      chk({o_flag_n, o_flag_v}, 16'h0003);
      step(5, 16'h0004);
      chk({mem.ram[16'h20], 7'h00, o_flag_z}, 16'h0001);
    end
  endtask
  // shift left on accumulator and memory, and on both
  task t_shift;
    begin
      ld(0, 64'h6981_0a29_0306_4025, 8);
      mem.ram[8] = 8'h40;
      mem.ram[16'h40] = 8'h41;
      boot(1'b0);
      step(2, 16'h0002);
      step(2, 16'h0003);
      chk({o_acc, 7'h00, o_flag_c}, 16'h0201);
      step(2, 16'h0005);
      chk(o_acc, 16'h0002);
      step(5, 16'h0007);
      chk({mem.ram[16'h40], 7'h00, o_flag_c}, 16'h8200);
      step(3, 16'h0009);
      chk(o_acc, 16'h0002);
    end
  endtask
  // bit branches, both senses and forms, forward and backward
  task t_bitbr;
    begin
      ld(0, 48'h6902_3304_233a, 6);
      ld(16'h40, 48'hf750_05e7_50f0, 6);
      mem.ram[16'h50] = 8'h80;
      boot(1'b0);
      step(2, 16'h0002);
      step(4, 16'h0004);
      step(4, 16'h0040);
      step(5, 16'h0043);
      step(5, 16'h0036);
    end
  endtask
  // flag branches taken and not taken
  task t_flagbr;
    begin
      ld(0, 16'h9010, 2);
      ld(16'h12, 48'hb010_6900_f008, 6);
      ld(16'h20, 56'h6980_0a90_20b0_e0, 7);
      ld(7, 32'h6901_f040, 4);
      mem.ram[16'h0b] = 8'hea;  // outside the subset, skipped as one byte
      boot(1'b0);
      step(2, 16'h0012);
      step(2, 16'h0014);
      step(2, 16'h0016);
      step(2, 16'h0020);
      step(2, 16'h0022);
      step(2, 16'h0023);
      step(2, 16'h0025);
      step(2, 16'h0007);
      step(2, 16'h0009);
      step(2, 16'h000b);
      chk(o_bad_op, 16'h0000);
      step(2, 16'h000c);
      chk({o_acc, 7'h00, o_bad_op}, 16'h0201);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task close_out;
    begin
      $display("mismatches %0d comparisons %0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  // main sequence
  initial begin
    fail_count      = 0;
    samples_checked = 0;
    i_nrst          = 1'b0;
    i_index_mode    = 1'b0;
    i_x_reg         = 8'h20;
    t_add;
    t_index;
    t_shift;
    t_bitbr;
    t_flagbr;
    close_out;
  end
  // a hang is cut short at 5000 cycles, well past the under one hundred cycles needed
  initial begin
    #100000;
    fail_count = fail_count + 1;
    close_out;
  end
endmodule
